// File: rtl/opl_pkg.sv
// Constants, enumerations and carrier structs for the operator panel block.
// Assumes a single 100 MHz clock and a 1 ms panel timebase.
package opl_pkg;

	// Clock and timebase
	localparam int CLK_NS   = 10;
	localparam int MS_NS    = 1000000;
	localparam int TICK_NS  = 1000000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;

	// Panel times in milliseconds, then in timebase ticks
	localparam int DEB_MS     = 10;
	localparam int HOLD_MS    = 2000;
	localparam int FAST_MS    = 200;
	localparam int SLOW_MS    = 1400;
	localparam int DEB_TICKS  = DEB_MS * (MS_NS / TICK_NS);
	localparam int HOLD_TICKS = HOLD_MS * (MS_NS / TICK_NS);
	localparam int FAST_HALF  = (FAST_MS * (MS_NS / TICK_NS)) / 2;
	localparam int SLOW_HALF  = (SLOW_MS * (MS_NS / TICK_NS)) / 2;

	// Register map, byte addresses
	localparam int             ADDR_W   = 8;
	localparam logic [7:0]     REG_CTRL = 8'h00;
	localparam logic [7:0]     REG_LOC  = 8'h04;
	localparam logic [7:0]     REG_STAT = 8'h08;
	localparam int             CTRL_LOCK_LSB = 0;
	localparam int             CTRL_DIR_BIT  = 4;
	localparam int             CTRL_MON_LSB  = 5;
	localparam logic [3:0]     LOCK_RST = 4'h0;
	localparam logic [1:0]     RESP_OKAY   = 2'b00;
	localparam logic [1:0]     RESP_SLVERR = 2'b10;

	// Key indices
	localparam int K_MODE = 0;
	localparam int K_SET  = 1;
	localparam int K_RUN  = 2;
	localparam int K_STOP = 3;
	localparam int K_LOC  = 4;
	localparam int K_UP   = 5;
	localparam int K_DOWN = 6;
	localparam int NKEY   = 7;

	typedef enum logic [2:0] {LOC_EXT, LOC_PANEL, LOC_JOG, LOC_NET, LOC_COMB1, LOC_COMB2} opl_loc_t;
	typedef enum logic [1:0] {DISP_MON, DISP_PARAM, DISP_HIST} opl_disp_t;
	typedef enum logic [1:0] {ITEM_FOUT, ITEM_FSET, ITEM_CURR, ITEM_VOLT} opl_item_t;

	typedef struct packed {
		logic running;
		logic reverse;
		logic start_present;
		logic output_stop_input;
		logic restart_dip;
		logic tune_done;
		logic incorrect_setting_alarm;
		logic pm_motor;
		logic test_op;
		logic plc_enable;
		logic fault;
	} opl_core_t;

	typedef struct packed {
		opl_loc_t loc;
		logic     start_fwd;
		logic     start_rev;
		logic     stop;
		logic     trip_reset;
		logic     up;
		logic     down;
		logic     set_confirm;
		logic     stop_warn_clr;
	} opl_cmd_t;

	typedef struct packed {
		logic hz;
		logic amp;
		logic panel_location;
		logic external_location;
		logic network_location;
		logic monitor_lamp;
		logic parameter_lamp;
		logic run;
		logic pm;
		logic plc;
	} opl_lamp_t;

endpackage : opl_pkg

// File: rtl/opl_debounce.sv
// Two-flop synchroniser and debouncer for one panel key.
// Assumes a one-cycle tick enable and an active-high key level.
`timescale 1ns/100ps
module opl_debounce #(
	parameter int DEB = 10
) (
	input  wire logic clk,   // System clock
	input  wire logic rst_n, // Async reset, active low
	input  wire logic pin,   // Raw key level
	input  wire logic tick,  // Timebase enable
	output logic      level  // Debounced key level
);
	typedef struct packed {
		logic       s1;
		logic       s2;
		logic       lvl;
		logic [7:0] cnt;
	} opl_deb_st_t;

	opl_deb_st_t st_q, st_d;

	always_comb begin
		st_d = st_q;
		st_d.s1 = pin;
		st_d.s2 = st_q.s1;
		if (st_q.s2 == st_q.lvl) begin
			st_d.cnt = '0;
		end else if (tick) begin
			if (st_q.cnt == 8'(DEB - 1)) begin
				st_d.lvl = st_q.s2;
				st_d.cnt = '0;
			end else begin
				st_d.cnt = st_q.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign level = st_q.lvl;

endmodule : opl_debounce

// File: rtl/opl_panel.sv
// Operator panel: key decoding, key lock, display mode and lamp drive.
// Assumes status from the control core on MCLK and keys straight from pins.
//
// Notes on behaviour
// - Hz lamp on actual, blinks set
// - A lamp for current, else both dark
// - Location lamps follow location, combined lights two
// - Reset comes up in external location
// - Monitor lamp on monitor screens, parameter lamp
// - Parameter lamp blinks in easy mode
// - Run lamp on forward, slow reverse blink
// - Fast run blink when start inhibited
// - Motor lamp on PM, blinks test
// - Logic lamp on, blinks on fault
// - Two second mode hold toggles key lock
// - Lock setting zero disables key lock
// - Mode plus location key enters easy
// - Mode key advances display mode
// - Location key steps panel, jog, external
// - Location key clears panel stop warning
// - Set confirms, advances monitor while running
// - Run key starts in set direction
// - Stop removes commands, resets on trip
// - Up and down keys adjust value
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module opl_panel
	import opl_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	input  wire logic                   MCLK,        // System clock
	input  wire logic                   RST_N,       // Async reset
	input  wire logic [NKEY-1:0]        KEY,         // Raw keys, high pressed
	input  wire opl_pkg::opl_core_t     CORE,        // Core status
	output opl_pkg::opl_cmd_t           CMD,         // Commands to core
	output opl_pkg::opl_lamp_t          LAMP,        // Indicator lamps
	input  wire logic [ADDR_W-1:0]      AWADDR,      // Write address
	input  wire logic                   AWVALID,     // Write address valid
	output logic                        AWREADY,     // Write address ready
	input  wire logic [31:0]            WDATA,       // Write data
	input  wire logic [3:0]             WSTRB,       // Write strobes
	input  wire logic                   WVALID,      // Write data valid
	output logic                        WREADY,      // Write data ready
	output logic [1:0]                  BRESP,       // Write response
	output logic                        BVALID,      // Write response valid
	input  wire logic                   BREADY,      // Write response ready
	input  wire logic [ADDR_W-1:0]      ARADDR,      // Read address
	input  wire logic                   ARVALID,     // Read address valid
	output logic                        ARREADY,     // Read address ready
	output logic [31:0]                 RDATA,       // Read data
	output logic [1:0]                  RRESP,       // Read response
	output logic                        RVALID,      // Read data valid
	input  wire logic                   RREADY       // Read data ready
);
	import opl_pkg::*;

	localparam int DW = $clog2(TICK_CYCLES);

	typedef struct packed {
		logic [DW-1:0]     div;
		logic              tick;
		logic [7:0]        fast_cnt;
		logic [10:0]       slow_cnt;
		logic              fast_ph;
		logic              slow_ph;
		logic [11:0]       hold_cnt;
		logic              hold_done;
		logic              locked;
		logic [NKEY-1:0]   prev;
		opl_disp_t         disp;
		logic              easy;
		logic [1:0]        screen;
		opl_loc_t          loc;
		logic [3:0]        lock_set;
		logic              dir;
		opl_item_t         mon_sel;
		opl_cmd_t          cmd;
		opl_lamp_t         lamp;
		logic              aw_have;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_have;
		logic [31:0]       w_data;
		logic              w_strb0;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} opl_st_t;

	opl_st_t         st_q, st_d;
	logic [NKEY-1:0] key_lvl;

	generate
		for (genvar k = 0; k < NKEY; k++) begin : g_key
			opl_debounce #(.DEB(DEB_TICKS)) u_deb (
				.clk   (MCLK),
				.rst_n (RST_N),
				.pin   (KEY[k]),
				.tick  (st_q.tick),
				.level (key_lvl[k])
			);
		end
	endgenerate

	always_comb begin
		logic [NKEY-1:0] press;
		logic            act;
		opl_item_t       item;
		logic [31:0]     ctrl_img;
		logic [31:0]     stat_img;
		logic            aw_fire;
		logic            w_fire;
		st_d = st_q;
		press = '0;
		act = 1'b0;
		item = ITEM_FOUT;
		ctrl_img = '0;
		stat_img = '0;
		aw_fire = AWVALID && !st_q.aw_have && !st_q.bvalid;
		w_fire = WVALID && !st_q.w_have && !st_q.bvalid;

		st_d.tick = 1'b0;
		if (st_q.div == DW'(TICK_CYCLES - 1)) begin
			st_d.div = '0;
			st_d.tick = 1'b1;
		end else begin
			st_d.div = st_q.div + DW'(1);
		end
		if (st_q.tick) begin
			if (st_q.fast_cnt == 8'(FAST_HALF - 1)) begin
				st_d.fast_cnt = '0;
				st_d.fast_ph = !st_q.fast_ph;
			end else begin
				st_d.fast_cnt = st_q.fast_cnt + 8'h01;
			end
			if (st_q.slow_cnt == 11'(SLOW_HALF - 1)) begin
				st_d.slow_cnt = '0;
				st_d.slow_ph = !st_q.slow_ph;
			end else begin
				st_d.slow_cnt = st_q.slow_cnt + 11'h001;
			end
		end

		st_d.prev = key_lvl;
		press = key_lvl & ~st_q.prev;

		if (!key_lvl[K_MODE] || st_q.lock_set == LOCK_RST) begin
			st_d.hold_cnt = '0;
			st_d.hold_done = 1'b0;
		end else if (st_q.tick && !st_q.hold_done) begin
			if (st_q.hold_cnt == 12'(HOLD_TICKS - 1)) begin
				st_d.hold_done = 1'b1;
				st_d.locked = !st_q.locked;
			end else begin
				st_d.hold_cnt = st_q.hold_cnt + 12'h001;
			end
		end
		if (st_q.lock_set == LOCK_RST) begin
			st_d.locked = 1'b0;
		end
		act = !st_q.locked;

		st_d.cmd.start_fwd = 1'b0;
		st_d.cmd.start_rev = 1'b0;
		st_d.cmd.stop = 1'b0;
		st_d.cmd.trip_reset = 1'b0;
		st_d.cmd.up = 1'b0;
		st_d.cmd.down = 1'b0;
		st_d.cmd.set_confirm = 1'b0;
		st_d.cmd.stop_warn_clr = 1'b0;

		if (act) begin
			// mode with location enters easy mode
			if ((press[K_MODE] && key_lvl[K_LOC]) || (press[K_LOC] && key_lvl[K_MODE])) begin
				st_d.easy = 1'b1;
			end else if (press[K_MODE]) begin
				if (st_q.easy) begin
					st_d.easy = 1'b0;
				end else begin
					case (st_q.disp)
						DISP_MON:   st_d.disp = DISP_PARAM;
						DISP_PARAM: st_d.disp = DISP_HIST;
						default:    st_d.disp = DISP_MON;
					endcase
					st_d.screen = '0;
				end
			end else if (press[K_LOC] && !st_q.easy) begin
				case (st_q.loc)
					LOC_PANEL: st_d.loc = LOC_JOG;
					LOC_JOG:   st_d.loc = LOC_EXT;
					default:   st_d.loc = LOC_PANEL;
				endcase
			end
			if (press[K_LOC]) begin
				st_d.cmd.stop_warn_clr = 1'b1;
			end
			if (press[K_SET]) begin
				if (CORE.running && st_q.disp == DISP_MON && !st_q.easy) begin
					st_d.screen = (st_q.screen == 2'd2) ? 2'd0 : st_q.screen + 2'd1;
				end else begin
					st_d.cmd.set_confirm = 1'b1;
				end
			end
			if (press[K_RUN]) begin
				st_d.cmd.start_fwd = !st_q.dir;
				st_d.cmd.start_rev = st_q.dir;
			end
			if (press[K_STOP]) begin
				st_d.cmd.stop = 1'b1;
				st_d.cmd.trip_reset = CORE.fault;
			end
			st_d.cmd.up = press[K_UP];
			st_d.cmd.down = press[K_DOWN];
		end

		case (st_q.screen)
			2'd0:    item = st_q.mon_sel;
			2'd1:    item = ITEM_CURR;
			default: item = ITEM_VOLT;
		endcase

		st_d.lamp.hz = 1'b0;
		st_d.lamp.amp = 1'b0;
		st_d.lamp.monitor_lamp = 1'b0;
		if (st_q.disp == DISP_MON && !st_q.easy) begin
			st_d.lamp.hz = (item == ITEM_FOUT) || (item == ITEM_FSET && st_q.slow_ph);
			st_d.lamp.amp = (item == ITEM_CURR);
			st_d.lamp.monitor_lamp = 1'b1;
		end
		st_d.lamp.parameter_lamp = st_q.easy ? st_q.slow_ph : (st_q.disp == DISP_PARAM);

		st_d.lamp.panel_location = (st_q.loc == LOC_PANEL) || (st_q.loc == LOC_JOG)
			|| (st_q.loc == LOC_COMB1) || (st_q.loc == LOC_COMB2);
		st_d.lamp.external_location = (st_q.loc == LOC_EXT) || (st_q.loc == LOC_COMB1)
			|| (st_q.loc == LOC_COMB2);
		st_d.lamp.network_location = (st_q.loc == LOC_NET);

		if (CORE.start_present && (CORE.output_stop_input || CORE.restart_dip || CORE.tune_done
			|| CORE.incorrect_setting_alarm)) begin
			st_d.lamp.run = st_q.fast_ph;
		end else if (CORE.running) begin
			st_d.lamp.run = CORE.reverse ? st_q.slow_ph : 1'b1;
		end else begin
			st_d.lamp.run = 1'b0;
		end
		st_d.lamp.pm = CORE.test_op ? st_q.slow_ph : CORE.pm_motor;
		st_d.lamp.plc = CORE.plc_enable && (!CORE.fault || st_q.slow_ph);
		st_d.cmd.loc = st_q.loc;

		// Register images
		ctrl_img[CTRL_LOCK_LSB +: 4] = st_q.lock_set;
		ctrl_img[CTRL_DIR_BIT] = st_q.dir;
		ctrl_img[CTRL_MON_LSB +: 2] = st_q.mon_sel;
		stat_img = {24'h000000, st_q.locked, st_q.easy, st_q.screen, st_q.disp, st_q.loc == LOC_EXT,
			st_q.hold_done};

		// Write channel: address and data in either order
		if (aw_fire) begin
			st_d.aw_have = 1'b1;
			st_d.aw_addr = AWADDR;
		end
		if (w_fire) begin
			st_d.w_have = 1'b1;
			st_d.w_data = WDATA;
			st_d.w_strb0 = WSTRB[0];
		end
		if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
			st_d.aw_have = 1'b0;
			st_d.w_have = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = RESP_OKAY;
			case (st_q.aw_addr)
				REG_CTRL: begin
					if (st_q.w_strb0) begin
						st_d.lock_set = st_q.w_data[CTRL_LOCK_LSB +: 4];
						st_d.dir = st_q.w_data[CTRL_DIR_BIT];
						st_d.mon_sel = opl_item_t'(st_q.w_data[CTRL_MON_LSB +: 2]);
					end
				end
				REG_LOC: begin
					if (st_q.w_strb0 && st_q.w_data[2:0] <= 3'(LOC_COMB2)) begin
						st_d.loc = opl_loc_t'(st_q.w_data[2:0]);
					end
				end
				REG_STAT: ;
				default: st_d.bresp = RESP_SLVERR;
			endcase
		end
		if (st_q.bvalid && BREADY) begin
			st_d.bvalid = 1'b0;
		end

		// Read channel
		if (ARVALID && !st_q.rvalid) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = RESP_OKAY;
			case (ARADDR)
				REG_CTRL: st_d.rdata = ctrl_img;
				REG_LOC:  st_d.rdata = {29'h00000000, st_q.loc};
				REG_STAT: st_d.rdata = stat_img;
				default: begin
					st_d.rdata = '0;
					st_d.rresp = RESP_SLVERR;
				end
			endcase
		end else if (st_q.rvalid && RREADY) begin
			st_d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q <= '0;
			st_q.loc <= LOC_EXT;
			st_q.lock_set <= LOCK_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign CMD = st_q.cmd;
	assign LAMP = st_q.lamp;
	assign AWREADY = !st_q.aw_have && !st_q.bvalid;
	assign WREADY = !st_q.w_have && !st_q.bvalid;
	assign BVALID = st_q.bvalid;
	assign BRESP = st_q.bresp;
	assign ARREADY = !st_q.rvalid;
	assign RVALID = st_q.rvalid;
	assign RDATA = st_q.rdata;
	assign RRESP = st_q.rresp;

endmodule : opl_panel

// File: dv/opl_operator.sv
// Operator model: presses and releases panel keys.
// Assumes the panel clock; keys are plain levels, high pressed.
`timescale 1ns/100ps
module opl_operator
	import opl_pkg::*;
(
	input  wire logic            clk, // Panel clock
	output logic      [NKEY-1:0] key  // Key levels
);
	initial key = '0;
	task automatic press(input int k, input int n);
		@(posedge clk);
		key[k] <= 1'b1;
		repeat (n) @(posedge clk);
		key[k] <= 1'b0;
		repeat (80) @(posedge clk);
	endtask : press
endmodule : opl_operator

// File: dv/opl_panel_sva.sv
// Checker for lamp and command relations of the panel.
// Bound to the panel top; sees only its ports.
`timescale 1ns/100ps
module opl_panel_sva
	import opl_pkg::*;
(
	input wire logic               MCLK,  // Clock
	input wire logic               RST_N, // Reset
	input wire opl_pkg::opl_core_t CORE,  // Core status
	input wire opl_pkg::opl_cmd_t  CMD,   // Commands
	input wire opl_pkg::opl_lamp_t LAMP   // Lamps
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	sequence idle3;
		(!CORE.running && !CORE.start_present) [*3];
	endsequence
	sequence pm3;
		(CORE.pm_motor && !CORE.test_op) [*3];
	endsequence
	sequence plc_off3;
		(!CORE.plc_enable) [*3];
	endsequence
	ext_lamp_a: assert property ($past(RST_N) |->
		LAMP.external_location == (CMD.loc inside {LOC_EXT, LOC_COMB1, LOC_COMB2}) ||
		LAMP.external_location == ($past(CMD.loc) inside {LOC_EXT, LOC_COMB1, LOC_COMB2}))
		else $error("external lamp wrong");
	panel_lamp_a: assert property (LAMP.panel_location |->
		CMD.loc inside {LOC_PANEL, LOC_JOG, LOC_COMB1, LOC_COMB2} ||
		$past(CMD.loc) inside {LOC_PANEL, LOC_JOG, LOC_COMB1, LOC_COMB2})
		else $error("panel lamp wrong");
	unit_excl_a: assert property (!(LAMP.hz && LAMP.amp)) else $error("both unit lamps lit");
	unit_mode_a: assert property ((LAMP.hz || LAMP.amp) |-> LAMP.monitor_lamp) else $error("unit lamp off monitor");
	mode_excl_a: assert property (!(LAMP.monitor_lamp && LAMP.parameter_lamp)) else $error("mode lamps both");
	run_off_a: assert property (idle3 |-> !LAMP.run) else $error("run lamp lit idle");
	pm_on_a: assert property (pm3 |-> LAMP.pm) else $error("motor lamp dark");
	plc_off_a: assert property (plc_off3 |-> !LAMP.plc) else $error("logic lamp lit");
	trip_stop_a: assert property (CMD.trip_reset |-> CMD.stop) else $error("reset without stop");
	dir_excl_a: assert property (!(CMD.start_fwd && CMD.start_rev)) else $error("both directions");
	stop_pulse_a: assert property (CMD.stop |=> !CMD.stop) else $error("stop pulse long");
endmodule : opl_panel_sva
bind opl_panel opl_panel_sva i_sva (.MCLK(MCLK), .RST_N(RST_N), .CORE(CORE), .CMD(CMD), .LAMP(LAMP));

// File: dv/opl_panel_tb_top.sv
// Self-checking bench for the operator panel.
// Drives keys through the operator model and registers over AXI4-Lite.
`timescale 1ns/100ps
module opl_panel_tb_top;
	import opl_pkg::*;
	logic              MCLK = 0, RST_N = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
	logic              AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [NKEY-1:0]   KEY;
	logic [ADDR_W-1:0] AWADDR = 0, ARADDR = 0;
	logic [31:0]       WDATA = 0, RDATA;
	logic [3:0]        WSTRB = 0;
	logic [1:0]        BRESP, RRESP;
	opl_core_t         CORE = '0;
	opl_cmd_t          CMD;
	opl_lamp_t         LAMP;
	logic [67:0]       exp_q[$];
	logic [7:0]        pv;
	logic [10:0]       cv[5] = '{11'h600, 11'h400, 11'h180, 11'h004, 11'h003};
	int                lb[5] = '{2, 2, 2, 1, 0}, lo[5] = '{1, 0, 13, 1, 1}, hi[5] = '{3, 0, 15, 3, 3};
	opl_loc_t          lt[3] = '{LOC_PANEL, LOC_JOG, LOC_EXT};
	int                err_total = 0, checked = 0, seed = 21, n, t;
	assign pv = {CMD.start_fwd, CMD.start_rev, CMD.stop, CMD.trip_reset, CMD.up, CMD.down, CMD.set_confirm,
		CMD.stop_warn_clr};
	always #5 MCLK = ~MCLK;
	opl_panel #(.TICK_CYCLES(4)) i_dut (
		.MCLK    (MCLK),
		.RST_N   (RST_N),
		.KEY     (KEY),
		.CORE    (CORE),
		.CMD     (CMD),
		.LAMP    (LAMP),
		.AWADDR  (AWADDR),
		.AWVALID (AWVALID),
		.AWREADY (AWREADY),
		.WDATA   (WDATA),
		.WSTRB   (WSTRB),
		.WVALID  (WVALID),
		.WREADY  (WREADY),
		.BRESP   (BRESP),
		.BVALID  (BVALID),
		.BREADY  (BREADY),
		.ARADDR  (ARADDR),
		.ARVALID (ARVALID),
		.ARREADY (ARREADY),
		.RDATA   (RDATA),
		.RRESP   (RRESP),
		.RVALID  (RVALID),
		.RREADY  (RREADY)
	);
	opl_operator i_op (.clk(MCLK), .key(KEY));
	task conclude;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	task chk(input logic [33:0] v, input logic [33:0] e);
		checked++;
		if (v !== e) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, v, e);
		end
	endtask : chk
	task got(input logic [33:0] v);
		logic [67:0] x;
		x = exp_q.size() ? exp_q.pop_front() : '1;
		chk(v & x[67:34], x[33:0]);
	endtask : got
	// Results are taken at the falling edge, where they are settled
	always @(negedge MCLK) begin
		if (BVALID && BREADY)
			got({BRESP, 32'h0});
		if (RVALID && RREADY)
			got({RRESP, RDATA});
		if (pv !== 8'h0)
			got({26'h0, pv});
	end
	task axi(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] m, input logic [33:0] e);
		logic ta, tw, tr, dn;
		exp_q.push_back({m, e});
		@(posedge MCLK);
		if (w) begin
			AWADDR <= a;
			WDATA <= d;
			WSTRB <= 4'hf;
			AWVALID <= 1;
			WVALID <= 1;
			BREADY <= 1;
		end else begin
			ARADDR <= a;
			ARVALID <= 1;
			RREADY <= 1;
		end
		for (n = 0; n < 50; n++) begin
			@(negedge MCLK);
			ta = AWVALID && AWREADY;
			tw = WVALID && WREADY;
			tr = ARVALID && ARREADY;
			dn = BVALID && BREADY || RVALID && RREADY;
			@(posedge MCLK);
			if (ta)
				AWVALID <= 0;
			if (tw)
				WVALID <= 0;
			if (tr)
				ARVALID <= 0;
			if (dn)
				break;
		end
		BREADY <= 0;
		RREADY <= 0;
		if (n == 50) begin
			err_total++;
			conclude();
		end
	endtask : axi
	task automatic key(input int k, input logic [7:0] e, input int h);
		if (e != 8'h0)
			exp_q.push_back({34'h3ffffffff, 26'h0, e});
		i_op.press(k, h);
	endtask : key
	task tog(input int b, input int l, input int u);
		logic p;
		repeat (8) @(negedge MCLK);
		t = 0;
		p = LAMP[b];
		repeat (5600) begin
			@(negedge MCLK);
			t += int'(LAMP[b] != p);
			p = LAMP[b];
		end
		chk(34'(t >= l && t <= u), 34'h1);
	endtask : tog
	initial begin
		repeat (100000) @(posedge MCLK);
		err_total++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge MCLK);
		RST_N <= 1;
		repeat (3) @(posedge MCLK);
		chk(34'(CMD.loc), 34'(LOC_EXT));
		chk(34'(LAMP.external_location), 34'h1);
		axi(0, REG_CTRL, 0, '1, 34'h0);
		axi(0, REG_LOC, 0, '1, 34'h0);
		axi(0, 8'h0c, 0, '1, {RESP_SLVERR, 32'h0});
		axi(1, 8'h0c, 32'h1, '1, {RESP_SLVERR, 32'h0});
		$display("end of register test");
		repeat (400) @(posedge MCLK) CORE <= 11'($random(seed));
		CORE <= '0;
		$display("end of random status test");
		key(K_RUN, 8'h80, 70);
		axi(1, REG_CTRL, 32'h10, '1, 34'h0);
		key(K_RUN, 8'h40, 70);
		key(K_STOP, 8'h20, 70);
		CORE.fault <= 1;
		key(K_STOP, 8'h30, 70);
		CORE.fault <= 0;
		key(K_UP, 8'h08, 70);
		key(K_DOWN, 8'h04, 70);
		key(K_SET, 8'h02, 70);
		for (n = 0; n < 3; n++) begin
			key(K_LOC, 8'h01, 70);
			chk(34'(CMD.loc), 34'(lt[n]));
			chk(34'(LAMP.external_location), 34'(n == 2));
		end
		axi(1, REG_LOC, 32'h3, '1, 34'h0);
		axi(0, REG_LOC, 0, '1, 34'h3);
		chk(34'({LAMP.panel_location, LAMP.external_location, LAMP.network_location}), 34'h1);
		axi(1, REG_LOC, 32'h4, '1, 34'h0);
		axi(0, REG_LOC, 0, '1, 34'h4);
		chk(34'({LAMP.panel_location, LAMP.external_location, LAMP.network_location}), 34'h6);
		axi(1, REG_LOC, 32'h5, '1, 34'h0);
		axi(0, REG_LOC, 0, '1, 34'h5);
		chk(34'({LAMP.panel_location, LAMP.external_location, LAMP.network_location}), 34'h6);
		axi(1, REG_LOC, 32'h0, '1, 34'h0);
		$display("end of key test");
		chk(34'({LAMP.hz, LAMP.amp, LAMP.monitor_lamp}), 34'h5);
		axi(1, REG_CTRL, 32'h30, '1, 34'h0);
		tog(9, 1, 3);
		chk(34'(LAMP.amp), 34'h0);
		axi(1, REG_CTRL, 32'h10, '1, 34'h0);
		key(K_MODE, 0, 70);
		axi(0, REG_STAT, 0, {2'b11, 32'hc}, 34'h4);
		chk(34'(LAMP.parameter_lamp), 34'h1);
		key(K_MODE, 0, 70);
		key(K_MODE, 0, 70);
		axi(0, REG_STAT, 0, {2'b11, 32'hc}, 34'h0);
		chk(34'(LAMP.monitor_lamp), 34'h1);
		CORE.running <= 1;
		key(K_SET, 0, 70);
		axi(0, REG_STAT, 0, {2'b11, 32'h30}, 34'h10);
		chk(34'({LAMP.hz, LAMP.amp}), 34'h1);
		key(K_SET, 0, 70);
		axi(0, REG_STAT, 0, {2'b11, 32'h30}, 34'h20);
		chk(34'({LAMP.hz, LAMP.amp}), 34'h0);
		CORE.running <= 0;
		fork
			key(K_LOC, 8'h01, 300);
			begin
				repeat (120) @(posedge MCLK);
				key(K_MODE, 0, 70);
			end
		join
		axi(0, REG_STAT, 0, {2'b11, 32'h40}, 34'h40);
		tog(3, 1, 3);
		key(K_MODE, 0, 70);
		$display("end of mode test");
		for (n = 0; n < 5; n++) begin
			CORE <= cv[n];
			tog(lb[n], lo[n], hi[n]);
		end
		CORE <= '0;
		$display("end of blink test");
		axi(1, REG_CTRL, 32'h1, '1, 34'h0);
		key(K_MODE, 0, 8300);
		axi(0, REG_STAT, 0, {2'b11, 32'h80}, 34'h80);
		key(K_RUN, 0, 70);
		axi(1, REG_CTRL, 32'h0, '1, 34'h0);
		axi(0, REG_STAT, 0, {2'b11, 32'h80}, 34'h0);
		key(K_RUN, 8'h80, 70);
		$display("end of lock test");
		repeat (20) @(posedge MCLK);
		chk(34'(exp_q.size()), 34'h0);
		conclude();
	end
endmodule : opl_panel_tb_top
